// File: flash_link_pkg.sv
// Shared constants, lane widths and lane mapping functions for the flash pin link.
package flash_link_pkg;
  typedef enum logic [1:0] {
    W_SINGLE = 2'b00,
    W_DUAL = 2'b01,
    W_QUAD = 2'b10
  } width_t;

  localparam int CLK_PERIOD_NS = 10;
  localparam int RESET_PULSE_MIN_NS = 200;
  localparam int RESET_PULSE_MIN_CYC = (RESET_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POWER_UP_INIT_NS = 300000;
  localparam int POWER_UP_INIT_CYC = (POWER_UP_INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCK_HALF_CYC = 8;
  localparam int MIN_SCK_HALF_CYC = 6;
  localparam int BYTE_BITS = 8;
  localparam int PROG_BUF_DEPTH = 16;
  localparam int SR_WRITE_DISABLE_POS = 7;
  localparam int CR_QUAD_ENABLE_POS = 1;
  localparam int SR2_IO3_RESET_POS = 5;
  localparam logic [7:0] SR_RESET = 8'h00;
  localparam logic [7:0] CR_RESET = 8'h00;
  localparam logic [7:0] SR2_RESET = 8'h00;
  localparam logic [7:0] BANK_RESET = 8'h00;
  localparam logic [7:0] PROG_FILL = 8'hff;

  function automatic logic [3:0] step_of(width_t w);
    case (w)
      W_DUAL: return 4'h2;
      W_QUAD: return 4'h4;
      default: return 4'h1;
    endcase
  endfunction : step_of

  // The serial-output end uses lane 1 in single mode, the serial-input end lane 0.
  function automatic logic [3:0] lane_mask(width_t w, logic so);
    case (w)
      W_DUAL: return 4'h3;
      W_QUAD: return 4'hf;
      default: return so ? 4'h2 : 4'h1;
    endcase
  endfunction : lane_mask

  function automatic logic [3:0] pack_out(logic [7:0] sh, width_t w, logic so);
    case (w)
      W_DUAL: return {2'b00, sh[7:6]};
      W_QUAD: return sh[7:4];
      default: return so ? {2'b00, sh[7], 1'b0} : {3'b000, sh[7]};
    endcase
  endfunction : pack_out

  function automatic logic [7:0] shift_in(logic [7:0] sh, logic [3:0] ln, width_t w, logic so);
    case (w)
      W_DUAL: return {sh[5:0], ln[1:0]};
      W_QUAD: return {sh[3:0], ln};
      default: return {sh[6:0], so ? ln[1] : ln[0]};
    endcase
  endfunction : shift_in
endpackage : flash_link_pkg

// File: flash_link_if.sv
// Pin-level link between the flash end and the host end, with pull-ups on the lanes.
`timescale 1ns/1ps
interface flash_link_if;
  logic sck;
  logic cs_n;
  logic reset_n;
  logic [3:0] host_o;
  logic [3:0] host_oe;
  logic [3:0] dev_o;
  logic [3:0] dev_oe;
  logic [3:0] lane;

  // An undriven lane reads high, as the internal pull-ups make it.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      lane[i] = dev_oe[i] ? dev_o[i] : (host_oe[i] ? host_o[i] : 1'b1);
    end
  end

  modport device (input sck, input cs_n, input reset_n, input lane, output dev_o, output dev_oe);
  modport host (output sck, output cs_n, output reset_n, output host_o, output host_oe,
                input lane);
endinterface : flash_link_if

// File: sync2.sv
// Two-flip-flop synchroniser for a group of level inputs.
`timescale 1ns/1ps
module sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_reg <= INIT;
      q <= INIT;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule : sync2

// File: flash_pin_device.sv
// Flash end of the pin link: lane muxing, select, pause and hardware reset handling.
//
// The register addresses and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
module flash_pin_device
  import flash_link_pkg::*;
#(
  parameter bit HAS_RESET_PIN = 1'b1,
  parameter int RESET_MIN_CYC = RESET_PULSE_MIN_CYC,
  parameter int INIT_CYC = POWER_UP_INIT_CYC
) (
  input wire logic clk,
  input wire logic rst,
  flash_link_if.device link,
  input wire logic xfer_dir,
  input wire width_t xfer_width,
  input wire logic [7:0] tx_data,
  input wire logic internal_busy,
  input wire logic reg_wr_req,
  input wire logic [7:0] sr_wdata,
  input wire logic [7:0] cr_wdata,
  input wire logic [7:0] sr2_wdata,
  input wire logic bank_wr,
  input wire logic [7:0] bank_wdata,
  input wire logic pb_wr,
  input wire logic [3:0] pb_addr,
  input wire logic [7:0] pb_wdata,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic tx_taken,
  output logic [7:0] pb_rdata,
  output logic [7:0] status_bits,
  output logic [7:0] config_bits,
  output logic [7:0] status2_bits,
  output logic [7:0] bank_addr,
  output logic write_rejected,
  output logic hw_reset_done,
  output logic active_power,
  output logic ready,
  output logic selected,
  output logic paused
);
  localparam int RW = $clog2(RESET_MIN_CYC + 1);
  localparam int IW = $clog2(INIT_CYC + 1);

  if (RESET_MIN_CYC < 1 || INIT_CYC < 1 || PROG_BUF_DEPTH > 16) begin : g_bad_param
    $error("flash_pin_device: counts must be at least one");
  end

  logic s_rst_n;
  logic s_cs_n;
  logic s_sck;
  logic [3:0] s_lane;
  logic sck_prev_reg;
  logic cs_prev_reg;
  logic sel_reg, sel_next;
  logic pause_reg, pause_next;
  logic drive_reg, drive_next;
  logic [RW-1:0] rcnt_reg, rcnt_next;
  logic [IW-1:0] init_reg, init_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [7:0] sh_reg, sh_next;
  logic [7:0] sr_reg, sr_next;
  logic [7:0] cr_reg, cr_next;
  logic [7:0] sr2_reg, sr2_next;
  logic [7:0] bank_reg, bank_next;
  logic [3:0] o_next, oe_next;
  logic [7:0] rx_data_next, cur;
  logic rise, fall, quad, io3_sel, hold_en, rst_low, rst_hold, act;
  logic rx_v, tx_t, wr_rej;
  logic [7:0] pb_mem [PROG_BUF_DEPTH];

  // Pins, the link clock among them, cross into clk before any logic reads them.
  // The link clock idles low, so its synchroniser and edge detector start low to avoid a false edge.
  sync2 #(.WIDTH(7), .INIT(7'h6f)) u_sync (
    .clk(clk),
    .rst(rst),
    .d({link.reset_n, link.cs_n, link.sck, link.lane}),
    .q({s_rst_n, s_cs_n, s_sck, s_lane})
  );

  assign status_bits = sr_reg;
  assign config_bits = cr_reg;
  assign status2_bits = sr2_reg;
  assign bank_addr = bank_reg;
  assign selected = sel_reg;
  assign paused = pause_reg;

  always_comb begin
    rise = s_sck && !sck_prev_reg;
    fall = !s_sck && sck_prev_reg;
    quad = cr_reg[CR_QUAD_ENABLE_POS];
    io3_sel = sr2_reg[SR2_IO3_RESET_POS];
    // Lane 3 only counts as reset when the quad transfer cannot be using it.
    rst_low = (HAS_RESET_PIN && !s_rst_n) ||
              (io3_sel && (!quad || s_cs_n) && !s_lane[3]);
    rcnt_next = '0;
    if (rst_low) begin
      rcnt_next = (rcnt_reg == RW'(RESET_MIN_CYC)) ? rcnt_reg : rcnt_reg + 1'b1;
    end
    rst_hold = rcnt_next == RW'(RESET_MIN_CYC);
    init_next = init_reg;
    if (rst_hold) begin
      init_next = IW'(INIT_CYC);
    end else if (init_reg != '0) begin
      init_next = init_reg - 1'b1;
    end
    sel_next = sel_reg;
    if (s_cs_n || rst_hold || init_reg != '0) begin
      sel_next = 1'b0;
    end else if (cs_prev_reg) begin
      sel_next = 1'b1;
    end
    hold_en = !io3_sel && !quad;
    pause_next = pause_reg;
    if (!sel_next || !hold_en) begin
      pause_next = 1'b0;
    end else if (!s_sck) begin
      pause_next = !s_lane[3];
    end
    act = sel_next && !pause_next;
    sh_next = sh_reg;
    cnt_next = cnt_reg;
    drive_next = drive_reg;
    o_next = link.dev_o;
    rx_v = 1'b0;
    tx_t = 1'b0;
    rx_data_next = rx_data;
    cur = sh_reg;
    if (!sel_next) begin
      cnt_next = '0;
      drive_next = 1'b0;
    end else if (!xfer_dir) begin
      drive_next = 1'b0;
      if (rise && act) begin
        sh_next = shift_in(sh_reg, s_lane, xfer_width, 1'b0);
        cnt_next = cnt_reg + step_of(xfer_width);
        if (cnt_next >= 4'(BYTE_BITS)) begin
          cnt_next = '0;
          rx_v = 1'b1;
          rx_data_next = sh_next;
        end
      end
    end else if ((fall || !sel_reg) && act) begin
      // The first bit of a frame goes out when the select is taken, ahead of the first rising edge.
      tx_t = cnt_reg == '0;
      cur = tx_t ? tx_data : sh_reg;
      o_next = pack_out(cur, xfer_width, 1'b1);
      sh_next = shift_in(cur, 4'h0, xfer_width, 1'b1);
      cnt_next = cnt_reg + step_of(xfer_width);
      if (cnt_next >= 4'(BYTE_BITS)) begin
        cnt_next = '0;
      end
      drive_next = 1'b1;
    end
    // A pause or deselect floats the lanes; a pause keeps the data for the resume, a deselect restarts the byte.
    oe_next = (drive_next && act) ? lane_mask(xfer_width, 1'b1) : 4'h0;
    sr_next = sr_reg;
    cr_next = cr_reg;
    sr2_next = sr2_reg;
    bank_next = bank_reg;
    wr_rej = 1'b0;
    if (rst_hold) begin
      sr_next = SR_RESET;
      cr_next = CR_RESET;
      sr2_next = SR2_RESET;
      bank_next = BANK_RESET;
    end else begin
      if (reg_wr_req) begin
        // Write protect exists only while lane 2 is not a quad data lane.
        if (sr_reg[SR_WRITE_DISABLE_POS] && !s_lane[2] && !quad) begin
          wr_rej = 1'b1;
        end else begin
          sr_next = sr_wdata;
          cr_next = cr_wdata;
          sr2_next = sr2_wdata;
        end
      end
      if (bank_wr) begin
        bank_next = bank_wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sck_prev_reg <= 1'b0;
      cs_prev_reg <= 1'b1;
      sel_reg <= 1'b0;
      pause_reg <= 1'b0;
      drive_reg <= 1'b0;
      rcnt_reg <= '0;
      init_reg <= IW'(INIT_CYC);
      cnt_reg <= '0;
      sh_reg <= 8'h00;
      sr_reg <= SR_RESET;
      cr_reg <= CR_RESET;
      sr2_reg <= SR2_RESET;
      bank_reg <= BANK_RESET;
      link.dev_o <= 4'h0;
      link.dev_oe <= 4'h0;
      rx_data <= 8'h00;
      rx_valid <= 1'b0;
      tx_taken <= 1'b0;
      write_rejected <= 1'b0;
      hw_reset_done <= 1'b0;
      active_power <= 1'b0;
      ready <= 1'b0;
    end else begin
      sck_prev_reg <= s_sck;
      cs_prev_reg <= s_cs_n;
      sel_reg <= sel_next;
      pause_reg <= pause_next;
      drive_reg <= drive_next;
      rcnt_reg <= rcnt_next;
      init_reg <= init_next;
      cnt_reg <= cnt_next;
      sh_reg <= sh_next;
      sr_reg <= sr_next;
      cr_reg <= cr_next;
      sr2_reg <= sr2_next;
      bank_reg <= bank_next;
      link.dev_o <= o_next;
      link.dev_oe <= oe_next;
      rx_data <= rx_data_next;
      rx_valid <= rx_v;
      tx_taken <= tx_t;
      write_rejected <= wr_rej;
      hw_reset_done <= rst_hold && (rcnt_reg != RW'(RESET_MIN_CYC));
      active_power <= !s_cs_n || internal_busy;
      ready <= init_next == '0;
    end
  end

  // Program buffer: every byte returns to all ones on either reset.
  always_ff @(posedge clk) begin
    if (rst || rst_hold) begin
      for (int i = 0; i < PROG_BUF_DEPTH; i++) begin
        pb_mem[i] <= PROG_FILL;
      end
      pb_rdata <= PROG_FILL;
    end else begin
      if (pb_wr) begin
        pb_mem[pb_addr] <= pb_wdata;
      end
      pb_rdata <= pb_mem[pb_addr];
    end
  end
endmodule : flash_pin_device

// File: flash_pin_host.sv
// Host end of the pin link: makes the serial clock and moves one byte per request.
`timescale 1ns/1ps
module flash_pin_host
  import flash_link_pkg::*;
#(
  parameter int HALF_CYC = SCK_HALF_CYC
) (
  input wire logic clk,
  input wire logic rst,
  flash_link_if.host link,
  input wire logic req,
  input wire logic req_read,
  input wire width_t req_width,
  input wire logic [7:0] req_wdata,
  input wire logic req_last,
  input wire logic quad_mode,
  input wire logic wp_level_n,
  input wire logic pause_req,
  input wire logic io3_reset_req,
  input wire logic reset_req,
  output logic [7:0] rsp_data,
  output logic rsp_valid,
  output logic busy
);
  localparam int CW = $clog2(HALF_CYC + 1);

  // The flash end's answer reaches the host's synchroniser output five clk cycles after a clock edge.
  if (HALF_CYC < MIN_SCK_HALF_CYC) begin : g_bad_half
    $error("flash_pin_host: serial clock half period too short");
  end

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SETUP = 3'b001,
    ST_LOW = 3'b010,
    ST_HIGH = 3'b011,
    ST_END = 3'b100
  } hstate_t;

  hstate_t st_reg, st_next;
  logic [CW-1:0] tick_reg, tick_next;
  logic [3:0] bits_reg, bits_next;
  logic [7:0] sh_reg, sh_next;
  logic read_reg, read_next;
  logic last_reg, last_next;
  width_t width_reg, width_next;
  logic [3:0] s_lane;
  logic [3:0] wr_lanes, o_next, oe_next;
  logic [7:0] rsp_data_next;
  logic sck_next, cs_next, rsp_v, half_done, abort;

  sync2 #(.WIDTH(4), .INIT(4'hf)) u_sync (
    .clk(clk),
    .rst(rst),
    .d(link.lane),
    .q(s_lane)
  );

  always_comb begin
    half_done = tick_reg == CW'(HALF_CYC - 1);
    abort = reset_req || io3_reset_req;
    tick_next = (st_reg == ST_IDLE || half_done) ? '0 : tick_reg + 1'b1;
    st_next = st_reg;
    bits_next = bits_reg;
    sh_next = sh_reg;
    read_next = read_reg;
    last_next = last_reg;
    width_next = width_reg;
    sck_next = link.sck;
    cs_next = link.cs_n;
    rsp_v = 1'b0;
    rsp_data_next = rsp_data;
    unique case (st_reg)
      ST_IDLE: begin
        if (req && !abort) begin
          sh_next = req_wdata;
          read_next = req_read;
          last_next = req_last;
          width_next = req_width;
          bits_next = '0;
          cs_next = 1'b0;
          st_next = link.cs_n ? ST_SETUP : ST_LOW;
        end
      end
      ST_SETUP: begin
        if (half_done) begin
          st_next = ST_LOW;
        end
      end
      ST_LOW: begin
        if (half_done) begin
          sck_next = 1'b1;
          st_next = ST_HIGH;
        end
      end
      ST_HIGH: begin
        if (half_done) begin
          sck_next = 1'b0;
          // Read data are taken late in the high phase, before the flash end moves them.
          sh_next = read_reg ? shift_in(sh_reg, s_lane, width_reg, 1'b1)
                             : shift_in(sh_reg, 4'h0, width_reg, 1'b0);
          bits_next = bits_reg + step_of(width_reg);
          if (bits_next >= 4'(BYTE_BITS)) begin
            rsp_v = read_reg;
            rsp_data_next = read_reg ? sh_next : rsp_data;
            st_next = last_reg ? ST_END : ST_IDLE;
          end else begin
            st_next = ST_LOW;
          end
        end
      end
      ST_END: begin
        if (half_done) begin
          cs_next = 1'b1;
          st_next = ST_IDLE;
        end
      end
      default: st_next = ST_IDLE;
    endcase
    if (abort) begin
      st_next = ST_IDLE;
      cs_next = 1'b1;
      sck_next = 1'b0;
    end
    wr_lanes = 4'h0;
    if ((st_next == ST_LOW || st_next == ST_HIGH) && !read_next) begin
      wr_lanes = lane_mask(width_next, 1'b0);
    end
    // Outside quad mode lane 2 carries write protect; outside quad data use lane 3 carries pause or reset.
    o_next = {cs_next ? !io3_reset_req : !pause_req, wp_level_n, 2'b00};
    oe_next = {!quad_mode || cs_next, !quad_mode, 2'b00};
    o_next = (o_next & ~wr_lanes) | (pack_out(sh_next, width_next, 1'b0) & wr_lanes);
    oe_next = oe_next | wr_lanes;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= ST_IDLE;
      tick_reg <= '0;
      bits_reg <= '0;
      sh_reg <= 8'h00;
      read_reg <= 1'b0;
      last_reg <= 1'b0;
      width_reg <= W_SINGLE;
      link.sck <= 1'b0;
      link.cs_n <= 1'b1;
      link.reset_n <= 1'b1;
      link.host_o <= 4'hc;
      link.host_oe <= 4'h0;
      rsp_data <= 8'h00;
      rsp_valid <= 1'b0;
      busy <= 1'b0;
    end else begin
      st_reg <= st_next;
      tick_reg <= tick_next;
      bits_reg <= bits_next;
      sh_reg <= sh_next;
      read_reg <= read_next;
      last_reg <= last_next;
      width_reg <= width_next;
      link.sck <= sck_next;
      link.cs_n <= cs_next;
      link.reset_n <= !reset_req;
      link.host_o <= o_next;
      link.host_oe <= oe_next;
      rsp_data <= rsp_data_next;
      rsp_valid <= rsp_v;
      busy <= st_next != ST_IDLE;
    end
  end
endmodule : flash_pin_host

// File: flash_link_checker.sv
// Concurrent checks on the pin link between the host end and the flash end.
`timescale 1ns/1ps
module flash_link_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic reset_n,
  input wire logic [3:0] host_o,
  input wire logic [3:0] host_oe,
  input wire logic [3:0] dev_o,
  input wire logic [3:0] dev_oe,
  input wire logic [3:0] lane
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // The flash end sees the select through synchronisers, so it may drive a few cycles on.
  a_desel_float: assert property (cs_n [*6] |-> dev_oe == 4'h0)
    else $error("flash lanes driven while deselected");
  a_no_contention: assert property (!cs_n |-> (dev_oe & host_oe) == 4'h0)
    else $error("both ends drive one lane");
  a_dev_after_fall: assert property ($changed(dev_o) && dev_oe != 4'h0 |-> !sck)
    else $error("flash data changed with the clock high");
  a_host_stable: assert property ($rose(sck) |-> $stable({host_o[1:0], host_oe[1:0]}))
    else $error("host data changed at a rising clock");
  a_sck_still: assert property (cs_n |-> !sck)
    else $error("serial clock high while deselected");
  a_sck_half: assert property ($changed(sck) |=> $stable(sck) [*5])
    else $error("serial clock phase too short");
  a_reset_float: assert property (!reset_n [*8] |-> dev_oe == 4'h0)
    else $error("flash lanes driven during reset");
  a_oe_shape: assert property (dev_oe inside {4'h0, 4'h2, 4'h3, 4'hf})
    else $error("flash drives an odd lane group");
  c_quad_read: cover property (dev_oe == 4'hf);
  c_dual_write: cover property (!cs_n && host_oe[1:0] == 2'b11 && sck);
  c_pin_reset: cover property (!reset_n [*8]);
  c_lane3_reset: cover property ((cs_n && !lane[3]) [*8]);
endmodule : flash_link_checker

// File: serial_flash_multi_io_pin_interface_tb_top.sv
// Self-checking bench: host end and flash end joined back to back over the pin link.
`timescale 1ns/1ps
module serial_flash_multi_io_pin_interface_tb_top;
  import flash_link_pkg::*;
  localparam int INIT_SIM = 50;
  localparam int RST_MIN_SIM = 4;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic req = 1'b0, req_read = 1'b0, req_last = 1'b0, quad_mode = 1'b0, xfer_dir = 1'b0;
  logic wp_level_n = 1'b1, pause_req = 1'b0, io3_reset_req = 1'b0, reset_req = 1'b0;
  logic internal_busy = 1'b0, reg_wr_req = 1'b0, bank_wr = 1'b0, pb_wr = 1'b0;
  width_t req_width = W_SINGLE, xfer_width = W_SINGLE;
  logic [7:0] req_wdata = 8'h00, tx_data = 8'h00, sr_wdata = 8'h00, cr_wdata = 8'h00;
  logic [7:0] sr2_wdata = 8'h00, bank_wdata = 8'h00, pb_wdata = 8'h00;
  logic [3:0] pb_addr = 4'h0;
  logic [7:0] rsp_data, rx_data, pb_rdata, status_bits, config_bits, status2_bits, bank_addr;
  logic rsp_valid, busy, rx_valid, write_rejected, hw_reset_done, active_power, ready, paused;
  logic [7:0] rxq[$], rsq[$], m_sr = 8'h00, m_cr = 8'h00, m_sr2 = 8'h00, v, d;
  int n_mismatch = 0, n_compared = 0, n_hw = 0, n_rej = 0, n_pause = 0, n;
  integer seed = 32'hc7074eb5;

  always #(CLK_PERIOD_NS / 2) clk = ~clk;

  flash_link_if link ();
  flash_pin_host #(.HALF_CYC(SCK_HALF_CYC)) flash_pin_host_inst (.clk(clk), .rst(rst),
    .link(link), .req(req), .req_read(req_read), .req_width(req_width), .req_wdata(req_wdata),
    .req_last(req_last), .quad_mode(quad_mode), .wp_level_n(wp_level_n), .pause_req(pause_req),
    .io3_reset_req(io3_reset_req), .reset_req(reset_req), .rsp_data(rsp_data),
    .rsp_valid(rsp_valid), .busy(busy));
  flash_pin_device #(.HAS_RESET_PIN(1'b1), .RESET_MIN_CYC(RST_MIN_SIM), .INIT_CYC(INIT_SIM))
    flash_pin_device_inst (.clk(clk), .rst(rst), .link(link), .xfer_dir(xfer_dir),
    .xfer_width(xfer_width), .tx_data(tx_data), .internal_busy(internal_busy),
    .reg_wr_req(reg_wr_req), .sr_wdata(sr_wdata), .cr_wdata(cr_wdata), .sr2_wdata(sr2_wdata),
    .bank_wr(bank_wr), .bank_wdata(bank_wdata), .pb_wr(pb_wr), .pb_addr(pb_addr),
    .pb_wdata(pb_wdata), .rx_data(rx_data), .rx_valid(rx_valid), .tx_taken(),
    .pb_rdata(pb_rdata), .status_bits(status_bits), .config_bits(config_bits),
    .status2_bits(status2_bits), .bank_addr(bank_addr), .write_rejected(write_rejected),
    .hw_reset_done(hw_reset_done), .active_power(active_power), .ready(ready), .selected(),
    .paused(paused));
  flash_link_checker flash_link_checker_inst (.clk(clk), .rst(rst), .sck(link.sck),
    .cs_n(link.cs_n), .reset_n(link.reset_n), .host_o(link.host_o), .host_oe(link.host_oe),
    .dev_o(link.dev_o), .dev_oe(link.dev_oe), .lane(link.lane));

  always @(posedge clk) begin
    if (rx_valid === 1'b1) rxq.push_back(rx_data);
    if (rsp_valid === 1'b1) rsq.push_back(rsp_data);
    if (hw_reset_done === 1'b1) n_hw++;
    if (write_rejected === 1'b1) n_rej++;
    if (paused === 1'b1) n_pause++;
  end

  task automatic chk_byte(input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk_byte

  task automatic chk_flag(input logic e, input logic g);
    chk_byte({7'h00, e}, {7'h00, g});
  endtask : chk_flag

  task automatic print_verdict();
    $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tick

  // Both user sides are set together: the flash end must know the width before the first edge.
  task automatic host_op(input logic rd, input width_t w, input logic [7:0] dt, input logic last);
    int k;
    @(posedge clk);
    req <= 1'b1;
    req_read <= rd;
    req_width <= w;
    req_wdata <= dt;
    req_last <= last;
    xfer_dir <= rd;
    xfer_width <= w;
    tx_data <= dt;
    @(posedge clk);
    req <= 1'b0;
    k = 0;
    do begin
      tick(1);
      k++;
    end while (busy !== 1'b0 && k < 400);
    if (busy !== 1'b0) n_mismatch++;
  endtask : host_op

  task automatic take(input logic rd, input logic [7:0] e);
    int k;
    k = 0;
    while ((rd ? rsq.size() : rxq.size()) == 0 && k < 40) begin
      tick(1);
      k++;
    end
    v = 8'hxx;
    if (rd && rsq.size() > 0) v = rsq.pop_front();
    if (!rd && rxq.size() > 0) v = rxq.pop_front();
    chk_byte(e, v);
  endtask : take

  task automatic wreg(input logic [7:0] s, input logic [7:0] c, input logic [7:0] s2);
    if (!(m_sr[SR_WRITE_DISABLE_POS] && !wp_level_n && !m_cr[CR_QUAD_ENABLE_POS])) begin
      m_sr = s;
      m_cr = c;
      m_sr2 = s2;
    end
    @(posedge clk);
    reg_wr_req <= 1'b1;
    sr_wdata <= s;
    cr_wdata <= c;
    sr2_wdata <= s2;
    @(posedge clk);
    reg_wr_req <= 1'b0;
    tick(2);
    chk_byte(m_sr, status_bits);
    chk_byte(m_cr, config_bits);
    chk_byte(m_sr2, status2_bits);
  endtask : wreg

  task automatic wait_ready(input int lo);
    int k;
    k = 0;
    while (ready !== 1'b1 && k < 4 * INIT_SIM) begin
      tick(1);
      k++;
    end
    chk_flag(1'b1, ready === 1'b1 && k >= lo);
  endtask : wait_ready

  initial begin
    #(CLK_PERIOD_NS * 40000);
    n_mismatch++;
    print_verdict();
  end

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    wait_ready(INIT_SIM - 4);
    wreg(8'h80, 8'h00, 8'h00);
    for (int p = 0; p < 2; p++) begin
      @(posedge clk);
      wp_level_n <= p[0];
      tick(4);
      n = n_rej;
      wreg(8'h00, 8'h00, 8'h00);
      chk_flag(!p[0], n_rej == n + 1);
    end
    for (int b = 1; b >= 0; b--) begin
      @(posedge clk);
      internal_busy <= b[0];
      tick(3);
      chk_flag(b[0], active_power);
    end
    rxq.delete();
    @(posedge clk);
    pause_req <= 1'b1;
    n = n_pause;
    host_op(1'b0, W_SINGLE, 8'h5a, 1'b1);
    tick(8);
    chk_flag(1'b1, n_pause > n);
    chk_flag(1'b1, rxq.size() == 0);
    @(posedge clk);
    pause_req <= 1'b0;
    // A reset cuts a byte short in mid-frame, first on the pin, then on lane 3.
    for (int s = 0; s < 2; s++) begin
      if (s == 1) wreg(m_sr, m_cr, 8'h20);
      d = 8'($random(seed));
      @(posedge clk);
      bank_wr <= 1'b1;
      bank_wdata <= d;
      pb_wr <= 1'b1;
      pb_addr <= 4'h9;
      pb_wdata <= ~d;
      @(posedge clk);
      bank_wr <= 1'b0;
      pb_wr <= 1'b0;
      tick(2);
      chk_byte(d, bank_addr);
      chk_byte(~d, pb_rdata);
      n = n_hw;
      rxq.delete();
      fork
        host_op(1'b0, W_SINGLE, 8'ha5, 1'b1);
        begin
          // Land the abort in a low clock phase so no clock phase is cut short.
          repeat (44) @(posedge clk);
          reset_req <= (s == 0);
          io3_reset_req <= (s == 1);
        end
      join
      repeat (RST_MIN_SIM + 8) @(posedge clk);
      reset_req <= 1'b0;
      io3_reset_req <= 1'b0;
      tick(1);
      chk_flag(1'b1, n_hw == n + 1);
      chk_flag(1'b0, ready);
      chk_byte(BANK_RESET, bank_addr);
      chk_byte(SR2_RESET, status2_bits);
      chk_flag(1'b1, rxq.size() == 0);
      // A lane 3 reset clears its own enable, so its init starts while the pin is still low.
      wait_ready(s == 0 ? INIT_SIM - 4 : INIT_SIM - 12);
      m_sr = SR_RESET;
      m_cr = CR_RESET;
      m_sr2 = SR2_RESET;
      for (int a = 0; a < PROG_BUF_DEPTH; a++) begin
        @(posedge clk);
        pb_addr <= 4'(a);
        tick(2);
        chk_byte(PROG_FILL, pb_rdata);
      end
    end
    n = n_hw;
    @(posedge clk);
    reset_req <= 1'b1;
    repeat (RST_MIN_SIM - 2) @(posedge clk);
    reset_req <= 1'b0;
    tick(12);
    chk_flag(1'b1, n_hw == n && ready === 1'b1);
    // Three writes share one frame, then three single-byte reads, in each lane width.
    for (int w = 0; w < 3; w++) begin
      if (w == 2) wreg(m_sr, 8'h02, m_sr2);
      @(posedge clk);
      quad_mode <= (w == 2);
      for (int i = 0; i < 6; i++) begin
        d = 8'($random(seed));
        host_op(i >= 3, width_t'(w), d, i >= 2);
        take(i >= 3, d);
      end
    end
    print_verdict();
  end
endmodule : serial_flash_multi_io_pin_interface_tb_top
